// [iao_decode.sv]
// Opcode decoder for the increment and OR-literal instructions
`timescale 1ns/1ps
`default_nettype none
module iao_decode
  import iao_pkg::*;
(
  input  wire logic [13:0] insn,      // Instruction word
  output var iao_op_type   op,        // Decoded operation
  output logic             dest_reg,  // 1: result to register
  output logic [6:0]       reg_addr,  // Register operand
  output logic [7:0]       literal    // Literal operand
);
  logic [5:0] opc;                   // Opcode field

  // Field extraction
  always_comb begin
    opc      = insn[IAO_OPC_MSB:IAO_OPC_LSB];
    dest_reg = insn[IAO_DEST_BIT];
    reg_addr = insn[IAO_ADDR_W-1:0];
    literal  = insn[IAO_DATA_W-1:0];
  end

  // Opcode match
  always_comb begin
    if (opc == IAO_OPC_INCSKIP) begin
      op = IAO_OP_INCSKIP;
    end else if (opc == IAO_OPC_INC) begin
      op = IAO_OP_INC;
    end else if (opc == IAO_OPC_ORLIT) begin
      op = IAO_OP_ORLIT;
    end else begin
      op = IAO_OP_NONE;
    end
  end
endmodule
`default_nettype wire

// [iao_exec.sv]
// Execution of increment, increment-skip and OR-literal instructions
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Opcode 001111 is increment-skip; flags untouched
// - Increment register; destination bit picks target
// - Zero result discards prefetch, two cycles
// - Skip tested on result, wraparound included
// - Opcode 001010 is increment; updates zero flag
// - Opcode 111000 is OR literal; updates zero
// - OR literal result always into accumulator
module iao_exec
  import iao_pkg::*;
(
  input  wire logic        core_clk,  // Core instruction clock
  input  wire logic        rst,       // Synchronous reset, high
  input  wire logic        insn_vld,  // Instruction word valid
  input  wire logic [13:0] insn,      // Prefetched instruction word
  input  wire logic [7:0]  reg_rdata, // Addressed register contents
  output logic [6:0]       reg_addr,  // Register operand address
  output logic             reg_we,    // Register write strobe
  output logic [7:0]       reg_wdata, // Register write data
  output logic [7:0]       acc,       // Accumulator
  output logic             zero_flag, // Zero status flag
  output logic             skip_nop,  // Discarding prefetch, executing nop
  output logic             done       // Instruction retired pulse
);
  iao_op_type op;                    // Decoded operation
  logic       dest_reg;              // Destination select
  logic [6:0] dec_addr;              // Decoded address
  logic [7:0] literal;               // Decoded literal
  logic [7:0] inc_sum;               // Register plus one
  logic [7:0] or_res;                // Accumulator OR literal
  logic       exec;                  // Instruction executes this cycle

  iao_decode u_dec (
    .insn     (insn),
    .op       (op),
    .dest_reg (dest_reg),
    .reg_addr (dec_addr),
    .literal  (literal)
  );

  // Increment, cut to eight bits so that 0xFF wraps to zero
  always_comb begin
    inc_sum = 8'(reg_rdata + IAO_ONE);
  end

  // OR of the accumulator with the literal field
  always_comb begin
    or_res = acc | literal;
  end

  // A word is taken only outside a skip cycle; the word that
  // arrives during the skip is the prefetched one and is dropped
  always_comb begin
    exec = insn_vld && !skip_nop;
  end

  // Skip cycle: next fetched word is replaced by a nop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      skip_nop <= 1'b0;
    end else if (exec && op == IAO_OP_INCSKIP && inc_sum == IAO_ZERO) begin
      skip_nop <= 1'b1;
    end else begin
      skip_nop <= 1'b0;
    end
  end

  // Accumulator update
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc <= IAO_ACC_RESET;
    end else if (exec && op == IAO_OP_ORLIT) begin
      acc <= or_res;
    end else if (exec && (op == IAO_OP_INC || op == IAO_OP_INCSKIP) && !dest_reg) begin
      acc <= inc_sum;
    end
  end

  // Register write port
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_we    <= 1'b0;
      reg_wdata <= IAO_ZERO;
      reg_addr  <= 7'h00;
    end else begin
      reg_we    <= exec && (op == IAO_OP_INC || op == IAO_OP_INCSKIP) && dest_reg;
      reg_wdata <= inc_sum;
      reg_addr  <= dec_addr;
    end
  end

  // Zero flag; increment-skip leaves it alone
  always_ff @(posedge core_clk) begin
    if (rst) begin
      zero_flag <= 1'b0;
    end else if (exec && op == IAO_OP_INC) begin
      zero_flag <= (inc_sum == IAO_ZERO);
    end else if (exec && op == IAO_OP_ORLIT) begin
      zero_flag <= (or_res == IAO_ZERO);
    end else begin
      zero_flag <= zero_flag;
    end
  end

  // Retire pulse: one per instruction, skip's nop included
  always_ff @(posedge core_clk) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= insn_vld;
    end
  end

  // Checks on the outputs one cycle after a word is taken; every
  // property is disabled while reset is held, so the first attempt
  // starts at the first edge with reset low
  sequence skip_seq;
    exec && op == IAO_OP_INCSKIP && inc_sum == IAO_ZERO;
  endsequence

  skip_two_cyc_a: assert property (@(posedge core_clk) disable iff (rst)
    skip_seq |=> skip_nop ##1 !skip_nop) else $error("skip not one nop cycle");
  skip_wrap_a: assert property (@(posedge core_clk) disable iff (rst)
    exec && op == IAO_OP_INCSKIP && reg_rdata == 8'hFF |=> skip_nop)
    else $error("wrap did not skip");
  noskip_inc_a: assert property (@(posedge core_clk) disable iff (rst)
    exec && op != IAO_OP_INCSKIP |=> !skip_nop) else $error("spurious skip");
  skip_flags_a: assert property (@(posedge core_clk) disable iff (rst)
    exec && op == IAO_OP_INCSKIP |=> $stable(zero_flag)) else $error("skip changed flag");
  inc_dest_a: assert property (@(posedge core_clk) disable iff (rst)
    exec && op == IAO_OP_INC && dest_reg |=> reg_we && reg_wdata == $past(inc_sum))
    else $error("increment not written to register");
  inc_acc_a: assert property (@(posedge core_clk) disable iff (rst)
    exec && op == IAO_OP_INC && !dest_reg |=> !reg_we && acc == $past(inc_sum))
    else $error("increment not written to accumulator");
  or_acc_a: assert property (@(posedge core_clk) disable iff (rst)
    exec && op == IAO_OP_ORLIT |=> !reg_we && acc == ($past(acc) | $past(literal)))
    else $error("or literal result wrong");
  zero_set_a: assert property (@(posedge core_clk) disable iff (rst)
    exec && (op == IAO_OP_INC || op == IAO_OP_ORLIT)
    |=> zero_flag == (($past(op) == IAO_OP_INC ? $past(inc_sum) : acc) == IAO_ZERO))
    else $error("zero flag wrong");
  or_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    exec && op == IAO_OP_ORLIT && or_res != IAO_ZERO |=> !zero_flag)
    else $error("or literal zero flag wrong");

  // Operation classes seen by the checks below
  sequence inc_reg_seq;
    exec && op == IAO_OP_INC && dest_reg;
  endsequence

  sequence skip_reg_seq;
    exec && op == IAO_OP_INCSKIP && dest_reg;
  endsequence

  sequence skip_acc_seq;
    exec && op == IAO_OP_INCSKIP && !dest_reg;
  endsequence

  sequence nonzero_seq;
    exec && op == IAO_OP_INCSKIP && inc_sum != IAO_ZERO;
  endsequence

  sequence discard_seq;
    skip_nop;
  endsequence

  sequence or_zero_seq;
    exec && op == IAO_OP_ORLIT && or_res == IAO_ZERO;
  endsequence

  // Register operand address follows the word into the write port
  inc_addr_a: assert property (@(posedge core_clk) disable iff (rst)
    inc_reg_seq |=> reg_addr == $past(dec_addr))
    else $error("increment write address wrong");

  // Plain increment zero flag tracks its own result
  inc_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    exec && op == IAO_OP_INC |=> zero_flag == ($past(inc_sum) == IAO_ZERO))
    else $error("increment zero flag wrong");

  // Plain increment wrap sets zero and never skips
  inc_wrap_a: assert property (@(posedge core_clk) disable iff (rst)
    exec && op == IAO_OP_INC && reg_rdata == 8'hFF |=> zero_flag && !skip_nop)
    else $error("increment wrap wrong");

  // Skip to register writes the wrapped sum back
  skip_reg_a: assert property (@(posedge core_clk) disable iff (rst)
    skip_reg_seq |=> reg_we && reg_wdata == $past(inc_sum))
    else $error("skip result not written to register");

  // Skip to accumulator leaves the register file alone
  skip_acc_a: assert property (@(posedge core_clk) disable iff (rst)
    skip_acc_seq |=> !reg_we && acc == $past(inc_sum))
    else $error("skip result not written to accumulator");

  // Nonzero increment-skip result runs in one cycle
  skip_none_a: assert property (@(posedge core_clk) disable iff (rst)
    nonzero_seq |=> !skip_nop)
    else $error("skip on nonzero result");

  // Discarded word changes no architectural state
  discard_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    discard_seq |=> !reg_we && !skip_nop && $stable(acc) && $stable(zero_flag))
    else $error("discarded word had an effect");

  // Zero OR result sets the zero flag
  or_zero_set_a: assert property (@(posedge core_clk) disable iff (rst)
    or_zero_seq |=> zero_flag && acc == IAO_ZERO)
    else $error("or literal zero not flagged");

  // Other opcodes write no register and leave acc, zero flag and skip alone
  ignore_other_a: assert property (@(posedge core_clk) disable iff (rst)
    exec && op == IAO_OP_NONE |=> !reg_we && !skip_nop && $stable(acc) && $stable(zero_flag))
    else $error("unknown opcode had an effect");

  // Every presented word, discarded ones too, retires
  retire_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
    insn_vld |=> done)
    else $error("word did not retire");

  // No retire pulse without a word
  retire_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    !insn_vld |=> !done)
    else $error("retire without a word");
endmodule
`default_nettype wire

// [iao_pkg.sv]
// Constants shared by the increment and OR-literal execution block
package iao_pkg;
  localparam int          IAO_INSN_W      = 14;           // Instruction word width
  localparam int          IAO_DATA_W      = 8;            // Data path width
  localparam int          IAO_ADDR_W      = 7;            // Register operand width
  localparam int          IAO_OPC_W       = 6;            // Opcode field width
  localparam int          IAO_OPC_MSB     = 13;           // Opcode field top bit
  localparam int          IAO_OPC_LSB     = 8;            // Opcode field bottom bit
  localparam int          IAO_DEST_BIT    = 7;            // Destination select bit
  localparam logic [5:0]  IAO_OPC_INCSKIP = 6'h0F;        // Increment, skip if zero
  localparam logic [5:0]  IAO_OPC_INC     = 6'h0A;        // Plain increment
  localparam logic [5:0]  IAO_OPC_ORLIT   = 6'h38;        // OR literal into accumulator
  localparam logic [7:0]  IAO_ACC_RESET   = 8'h00;        // Accumulator reset value
  localparam logic [7:0]  IAO_ZERO        = 8'h00;        // All-zero data value
  localparam logic [7:0]  IAO_ONE         = 8'h01;        // Increment step
  localparam logic [13:0] IAO_NOP_WORD    = 14'h0000;     // No-operation word

  // Kind of operation decoded from the opcode
  typedef enum logic [1:0] {
    IAO_OP_NONE    = 2'b00,
    IAO_OP_INC     = 2'b01,
    IAO_OP_INCSKIP = 2'b10,
    IAO_OP_ORLIT   = 2'b11
  } iao_op_type;
endpackage

// [tb_top.sv]
// Self-checking testbench for the increment and OR-literal execution block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import iao_pkg::*;
;
  logic        core_clk  = 1'h0;    // Core clock
  logic        rst       = 1'h1;    // Synchronous reset
  logic        insn_vld  = 1'h0;    // Word valid
  logic [13:0] insn      = 14'h0000; // Word presented
  logic [7:0]  reg_rdata = 8'h00;   // Operand read data
  logic [6:0]  reg_addr;            // Write address
  logic        reg_we;              // Write strobe
  logic [7:0]  reg_wdata;           // Write data
  logic [7:0]  acc;                 // Accumulator
  logic        zero_flag;           // Zero flag
  logic        skip_nop;            // Discard cycle
  logic        done;                // Retire pulse
  int          error_cnt  = 0;      // Mismatches
  int          n_compared = 0;      // Comparisons

  // Clock, 8 ns period
  always #4 core_clk = ~core_clk;

  iao_exec dut (.core_clk(core_clk), .rst(rst), .insn_vld(insn_vld), .insn(insn),
    .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_we(reg_we), .reg_wdata(reg_wdata),
    .acc(acc), .zero_flag(zero_flag), .skip_nop(skip_nop), .done(done));

  // Compare one value, count and report
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Present one word at a rising edge; outputs then show the word before
  task automatic present(input logic [13:0] w, input logic [7:0] r);
    @(posedge core_clk);
    insn      <= w;
    reg_rdata <= r;
    insn_vld  <= 1'h1;
    @(negedge core_clk);
  endtask

  // Stop presenting; outputs then show the last word presented
  task automatic idle;
    @(posedge core_clk);
    insn_vld <= 1'h0;
    @(negedge core_clk);
    chk({7'h00, done}, 8'h01);
  endtask

  // One word on its own, judged once its results stand
  task automatic exec(input logic [13:0] w, input logic [7:0] r);
    present(w, r);
    idle;
  endtask

  // OR literal: zero and nonzero results, accumulator only
  task automatic t_orlit;
    @(negedge core_clk);
    chk(acc, IAO_ACC_RESET);
    exec({IAO_OPC_ORLIT, 8'h00}, 8'h5A);
    chk(acc, 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
    exec({IAO_OPC_ORLIT, 8'h35}, 8'h00);
    chk(acc, 8'h35);
    chk({7'h00, zero_flag}, 8'h00);
    chk({7'h00, reg_we}, 8'h00);
    exec({IAO_OPC_ORLIT, 8'h8A}, 8'h00);
    chk(acc, 8'hBF);
    $display("test orlit done");
  endtask

  // Plain increment to accumulator with wrap, then to top register
  task automatic t_inc;
    exec({IAO_OPC_INC, 1'h0, 7'h00}, 8'hFF);
    chk(acc, 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
    chk({7'h00, skip_nop}, 8'h00);
    chk({7'h00, reg_we}, 8'h00);
    exec({IAO_OPC_INC, 1'h1, 7'h7F}, 8'h41);
    chk({7'h00, reg_we}, 8'h01);
    chk({1'h0, reg_addr}, 8'h7F);
    chk(reg_wdata, 8'h42);
    chk({7'h00, zero_flag}, 8'h00);
    chk(acc, 8'h00);
    present({IAO_OPC_INC, 1'h0, 7'h11}, 8'h0F);
    present({IAO_OPC_ORLIT, 8'h01}, 8'h00);
    chk(acc, 8'h10);
    idle;
    chk(acc, 8'h11);
    chk({7'h00, zero_flag}, 8'h00);
    $display("test inc done");
  endtask

  // Increment-skip: wrap to register, discard, no skip, wrap to accumulator
  task automatic t_skip;
    present({IAO_OPC_INCSKIP, 1'h1, 7'h05}, 8'hFF);
    present({IAO_OPC_ORLIT, 8'hFF}, 8'h00);
    chk({7'h00, reg_we}, 8'h01);
    chk({1'h0, reg_addr}, 8'h05);
    chk(reg_wdata, 8'h00);
    chk({7'h00, skip_nop}, 8'h01);
    chk({7'h00, zero_flag}, 8'h00);
    idle;
    chk(acc, 8'h11);
    chk({7'h00, skip_nop}, 8'h00);
    chk({7'h00, reg_we}, 8'h00);
    exec({IAO_OPC_INCSKIP, 1'h0, 7'h03}, 8'h20);
    chk(acc, 8'h21);
    chk({7'h00, skip_nop}, 8'h00);
    present({IAO_OPC_INCSKIP, 1'h0, 7'h03}, 8'hFF);
    present({IAO_OPC_ORLIT, 8'h55}, 8'h00);
    chk(acc, 8'h00);
    chk({7'h00, skip_nop}, 8'h01);
    chk({7'h00, zero_flag}, 8'h00);
    chk({7'h00, reg_we}, 8'h00);
    idle;
    chk(acc, 8'h00);
    chk({7'h00, skip_nop}, 8'h00);
    exec(14'h3FFF, 8'h00);
    chk(acc, 8'h00);
    chk({7'h00, reg_we}, 8'h00);
    chk({7'h00, zero_flag}, 8'h00);
    $display("test skip done");
  endtask

  // Print counts and verdict, then stop
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'h0;
    t_orlit;
    t_inc;
    t_skip;
    conclude;
  end
endmodule
`default_nettype wire
